// File: src/timer_time_base_unit.sv
// Time-base unit: prescaler, counter and auto-reload with update-event logic.
// Assumes an AXI4-Lite master on the same clock; all inputs synchronous to clk.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module timer_time_base_unit (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irqOut,
  output logic             dmaReq
);
  import time_base_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]  ctrlReg;
  logic [15:0] ienReg;
  logic        updFlagReg;
  logic [15:0] pscPreReg;
  logic [15:0] pscShadowReg;
  logic [15:0] pscCntReg;
  logic [15:0] arPreReg;
  logic [15:0] arShadowReg;
  logic [15:0] cntReg;
  logic        downReg;        // current direction in center mode
  logic        runDlyReg;      // run enable seen one cycle ago
  logic        ugReg;          // pending software update, self-clearing
  logic [7:0]  awAddrReg;
  logic        awHeldReg;
  logic [31:0] wDataReg;
  logic [3:0]  wStrbReg;
  logic        wHeldReg;

  // control decode
  logic        runEn;
  logic        updDis;
  logic        urs;
  logic        arpe;
  logic [1:0]  centerSel;
  count_mode_t mode;
  assign runEn     = ctrlReg[CTRL_RUN_BIT];
  assign updDis    = ctrlReg[CTRL_UPDOFF_BIT];
  assign urs       = ctrlReg[CTRL_URS_BIT];
  assign arpe      = ctrlReg[CTRL_ARPE_BIT];
  assign centerSel = ctrlReg[CTRL_CAM_LO +: 2];

  // mode select: center whenever field nonzero, else direction bit
  always_comb begin
    if (centerSel != 2'b00) begin
      mode = MODE_CENTER;
    end else if (ctrlReg[CTRL_DIR_BIT]) begin
      mode = MODE_DOWN;
    end else begin
      mode = MODE_UP;
    end
  end

  // ************************************************************
  // bus write path
  // ************************************************************
  logic wrFire;
  logic [31:0] wrData;
  assign wrFire = awHeldReg && wHeldReg && !s_axi_bvalid;
  always_comb begin
    wrData = '0;
    for (int b = 0; b < 4; b++) begin
      if (wStrbReg[b]) begin
        wrData[b*8 +: 8] = wDataReg[b*8 +: 8];
      end
    end
  end
  logic wrCtrl;
  logic wrIen;
  logic wrEvt;
  logic wrCnt;
  logic wrPsc;
  logic wrAr;
  logic wrClr;
  assign wrCtrl = wrFire && awAddrReg == CTRL_OFS;
  assign wrIen  = wrFire && awAddrReg == IEN_OFS;
  assign wrEvt  = wrFire && awAddrReg == EVTGEN_OFS;
  assign wrCnt  = wrFire && awAddrReg == CNT_OFS;
  assign wrPsc  = wrFire && awAddrReg == PSC_OFS;
  assign wrAr   = wrFire && awAddrReg == AR_OFS;
  assign wrClr  = wrFire && awAddrReg == CLR_OFS;

  // address and data taken in either order, held until the write fires
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeldReg <= 1'b0;
      wHeldReg  <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldReg <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeldReg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeldReg <= 1'b0;
      end
    end
  end

  // ready registered: high while the slot is free and no write response is pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !awHeldReg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHeldReg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // write response, error for unmapped offsets and for the read-only status offset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddrReg[1:0] == 2'b00 && awAddrReg <= CLR_OFS
                       && awAddrReg != STS_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // control and preload registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlReg <= CTRL_RST[7:0];
      ienReg  <= 16'h0000;
    end else begin
      if (wrCtrl) begin
        ctrlReg <= wrData[7:0] & CTRL_MASK;
      end
      if (wrIen) begin
        ienReg <= wrData[15:0];
      end
    end
  end

  // preloads writable at any time, also while running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pscPreReg <= PSC_RST;
      arPreReg  <= AR_RST;
    end else begin
      if (wrPsc) begin
        pscPreReg <= wrData[15:0];
      end
      if (wrAr) begin
        arPreReg <= wrData[15:0];
      end
    end
  end

  // software update request: one cycle pending then cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ugReg <= 1'b0;
    end else begin
      ugReg <= wrEvt && wrData[EVT_UG_BIT];
    end
  end

  // ************************************************************
  // counting engine
  // ************************************************************
  // run delay gives the one-cycle start latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runDlyReg <= 1'b0;
    end else begin
      runDlyReg <= runEn;
    end
  end

  logic tick;
  logic ovf;
  logic udf;
  logic hwEvt;
  logic swEvt;
  logic updEvt;
  assign tick = runEn && runDlyReg && (pscCntReg == pscShadowReg);
  assign ovf = tick && ((mode == MODE_UP && cntReg >= arShadowReg)
               || (mode == MODE_CENTER && !downReg && cntReg + 16'h0001 >= arShadowReg));
  assign udf = tick && ((mode == MODE_DOWN && cntReg == 16'h0000)
               || (mode == MODE_CENTER && downReg && cntReg <= 16'h0001));
  assign hwEvt = (ovf || udf) && !updDis;
  assign swEvt = ugReg && !updDis;
  assign updEvt = hwEvt || swEvt;

  // the reload value used for this cycle's wrap: preload value first on an update event with preload on
  logic [15:0] arNow;
  assign arNow = (updEvt && arpe) ? arPreReg : arShadowReg;

  // prescaler counter: restarts on every update event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pscCntReg <= 16'h0000;
    end else if (updEvt) begin
      pscCntReg <= 16'h0000;
    end else if (runEn && runDlyReg) begin
      pscCntReg <= (pscCntReg == pscShadowReg) ? 16'h0000 : pscCntReg + 16'h0001;
    end
  end

  // prescaler shadow moves on update, reload shadow only with preload on; while preload is off the reload shadow takes a write directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pscShadowReg <= PSC_RST;
      arShadowReg  <= AR_RST;
    end else begin
      if (updEvt) begin
        pscShadowReg <= pscPreReg;
      end
      if (!arpe && wrAr) begin
        arShadowReg <= wrData[15:0];
      end else if (updEvt && arpe) begin
        arShadowReg <= arPreReg;
      end
    end
  end

  // counter value and center-mode direction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cntReg  <= CNT_RST;
      downReg <= 1'b0;
    end else if (wrCnt) begin
      cntReg <= wrData[15:0];
    end else if (swEvt) begin
      cntReg  <= (mode == MODE_DOWN) ? arNow : 16'h0000;
      downReg <= 1'b0;
    end else if (tick) begin
      unique case (mode)
        MODE_UP: begin
          cntReg <= (cntReg >= arShadowReg) ? 16'h0000 : cntReg + 16'h0001;
          downReg <= 1'b0;
        end
        MODE_DOWN: begin
          cntReg <= (cntReg == 16'h0000) ? arNow : cntReg - 16'h0001;
          downReg <= 1'b0;
        end
        MODE_CENTER: begin
          if (!downReg) begin
            if (cntReg + 16'h0001 >= arNow) begin
              cntReg  <= arNow;
              downReg <= 1'b1;
            end else begin
              cntReg <= cntReg + 16'h0001;
            end
          end else if (cntReg <= 16'h0001) begin
            cntReg  <= 16'h0000;
            downReg <= 1'b0;
          end else begin
            cntReg <= cntReg - 16'h0001;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // update flag, interrupt and dma request
  // ************************************************************
  logic setFlag;
  assign setFlag = hwEvt || (swEvt && !urs);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      updFlagReg <= 1'b0;
    end else if (setFlag) begin
      updFlagReg <= 1'b1;
    end else if (wrClr && wrData[STS_UPD_BIT]) begin
      updFlagReg <= 1'b0;
    end
  end

  // interrupt level follows enabled flag; dma pulses per flagged event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
      dmaReq <= 1'b0;
    end else begin
      irqOut <= (updFlagReg || setFlag) && ienReg[IEN_IRQ_BIT] && !(wrClr && wrData[STS_UPD_BIT] && !setFlag);
      dmaReq <= setFlag && ienReg[IEN_DMA_BIT];
    end
  end

  // ************************************************************
  // bus read path
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          CTRL_OFS:   s_axi_rdata <= {24'h000000, ctrlReg};
          IEN_OFS:    s_axi_rdata <= {16'h0000, ienReg};
          STS_OFS:    s_axi_rdata <= {31'h0000_0000, updFlagReg};
          EVTGEN_OFS: s_axi_rdata <= 32'h0000_0000;
          CNT_OFS:    s_axi_rdata <= {16'h0000, cntReg};
          PSC_OFS:    s_axi_rdata <= {16'h0000, pscPreReg};
          AR_OFS:     s_axi_rdata <= {16'h0000, arPreReg};
          CLR_OFS:    s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_swReq;
    wrEvt && wrData[EVT_UG_BIT] && !updDis;
  endsequence
  sequence s_restart;
    pscCntReg == 16'h0000 && !ugReg;
  endsequence

  a_sw_restart: assert property (@(posedge clk) disable iff (rst)
    s_swReq ##1 !wrCnt |=> s_restart) else $error("software update did not restart prescaler");
  a_gen_selfclear: assert property (@(posedge clk) disable iff (rst)
    ugReg |=> !ugReg) else $error("update generate did not self-clear");
  a_urs_noflag: assert property (@(posedge clk) disable iff (rst)
    (swEvt && urs && !hwEvt && !updFlagReg) |=> !updFlagReg) else $error("flag set despite request select");
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    hwEvt |=> updFlagReg) else $error("update event did not set flag");
  a_upd_block: assert property (@(posedge clk) disable iff (rst)
    updDis && !wrAr |=> $stable(pscShadowReg) && (arpe ? $stable(arShadowReg) : 1'b1))
    else $error("shadow moved while updates disabled");
  a_up_wrap: assert property (@(posedge clk) disable iff (rst)
    (mode == MODE_UP && tick && cntReg == arShadowReg && !wrCnt && !ugReg) |=> cntReg == 16'h0000)
    else $error("up counter did not wrap to zero");
  a_down_reload: assert property (@(posedge clk) disable iff (rst)
    (mode == MODE_DOWN && udf && !wrCnt && !ugReg) |=> cntReg == $past(arNow))
    else $error("down counter did not reload");
  a_start_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(runEn) |-> !tick ##1 $stable(cntReg) || $past(wrCnt) || $past(ugReg))
    else $error("counter moved in first enabled cycle");
  a_stopped_hold: assert property (@(posedge clk) disable iff (rst)
    (!runEn && !wrCnt && !ugReg) |=> $stable(cntReg)) else $error("counter moved while disabled");
  a_irq_follow: assert property (@(posedge clk) disable iff (rst)
    (updFlagReg && ienReg[IEN_IRQ_BIT] && !wrClr) |=> irqOut) else $error("interrupt missing");

endmodule : timer_time_base_unit
`default_nettype wire

// File: src/time_base_pkg.sv
// Constants for the timer time-base unit: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package time_base_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00; // timer_control_one
  localparam logic [7:0] IEN_OFS    = 8'h04; // interrupt/dma enable
  localparam logic [7:0] STS_OFS    = 8'h08; // timer_status_reg
  localparam logic [7:0] EVTGEN_OFS = 8'h0C; // event_generation_reg
  localparam logic [7:0] CNT_OFS    = 8'h10; // counter_value_reg
  localparam logic [7:0] PSC_OFS    = 8'h14; // prescaler_value_reg
  localparam logic [7:0] AR_OFS     = 8'h18; // auto_reload_reg
  localparam logic [7:0] CLR_OFS    = 8'h1C; // status clear, write-only

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int CTRL_RUN_BIT  = 0; // counter_run_enable
  localparam int CTRL_UPDOFF_BIT = 1; // update_disable
  localparam int CTRL_URS_BIT  = 2; // update_request_select
  localparam int CTRL_DIR_BIT  = 4; // direction, 1 = down
  localparam int CTRL_CAM_LO   = 5; // center_align_select [6:5]
  localparam int CTRL_ARPE_BIT = 7; // reload_preload_enable
  localparam logic [7:0] CTRL_MASK = 8'hF7;

  // status / enable bits
  localparam int STS_UPD_BIT = 0; // update_flag
  localparam int IEN_IRQ_BIT = 0; // update interrupt enable
  localparam int IEN_DMA_BIT = 8; // update dma enable
  localparam int EVT_UG_BIT  = 0; // update_generate

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PSC_RST  = 16'h0000;
  localparam logic [15:0] AR_RST   = 16'hFFFF;
  localparam logic [15:0] CNT_RST  = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_UP,
    MODE_DOWN,
    MODE_CENTER
  } count_mode_t;

endpackage : time_base_pkg

// File: dv/tb.sv
// Self-checking bench for the timer time-base unit, driven over AXI4-Lite.
// Assumes time_base_pkg and the top module are compiled first; one clock only.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import time_base_pkg::*;

  // ************************************************************
  // signals and control words
  // ************************************************************
  logic        clk = 1'b0;
  logic        rst;
  logic [7:0]  awAddr;
  logic        awValid;
  logic        awReady;
  logic [31:0] wData;
  logic        wValid;
  logic        wReady;
  logic [1:0]  bResp;
  logic        bValid;
  logic        bReady;
  logic [7:0]  arAddr;
  logic        arValid;
  logic        arReady;
  logic [31:0] rData;
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady;
  logic        irqOut;
  logic        dmaReq;
  int          n_fail;
  int          compares;
  int          cyc = 0;
  int          t0;
  localparam logic [31:0] RUN   = 32'h1 << CTRL_RUN_BIT;
  localparam logic [31:0] UDIS  = 32'h1 << CTRL_UPDOFF_BIT;
  localparam logic [31:0] URS   = 32'h1 << CTRL_URS_BIT;
  localparam logic [31:0] DOWN  = 32'h1 << CTRL_DIR_BIT;
  localparam logic [31:0] ARPE  = 32'h1 << CTRL_ARPE_BIT;

  timer_time_base_unit u_dut (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .irqOut(irqOut), .dmaReq(dmaReq)
  );

  // 4 ns clock; cycle count moves on the rising edge so negedge readers see it settled
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chkResp(input string name, input logic [1:0] exp, input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : chkResp

  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // a wait that ran out ends the run at once
  task automatic hang(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    results();
  endtask : hang

  // ************************************************************
  // bus tasks: payload held until each channel's ready edge
  // ************************************************************
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    @(posedge clk);
    awAddr  <= a;
    awValid <= 1'b1;
    wData   <= d;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!awDone && awReady === 1'b1) begin
        awDone = 1;
        awValid <= 1'b0;
      end
      if (!wDone && wReady === 1'b1) begin
        wDone = 1;
        wValid <= 1'b0;
      end
      if (bValid === 1'b1) begin
        resp = bResp;
        bReady <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit arDone;
    arDone = 0;
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!arDone && arReady === 1'b1) begin
        arDone = 1;
        arValid <= 1'b0;
      end
      if (rValid === 1'b1) begin
        d = rData;
        resp = rResp;
        rReady <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask : axiRead

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    chkResp("write response", RESP_OKAY, r);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    chkResp("read response", RESP_OKAY, r);
    chk(name, exp, d);
  endtask : rd

  // update events are timed by the dma pulse, one per flagged update
  task automatic waitPulse();
    for (int n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (dmaReq === 1'b1) begin
        t0 = cyc;
        return;
      end
    end
    hang("update pulse");
  endtask : waitPulse

  task automatic pulseGap(input string name, input int exp);
    for (int n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (dmaReq === 1'b1) begin
        chk(name, 32'(exp), 32'(cyc - t0));
        t0 = cyc;
        return;
      end
    end
    hang(name);
  endtask : pulseGap

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic testReset();
    logic [31:0] d;
    logic [1:0]  r;
    rd("control", CTRL_OFS, 32'h0);
    rd("enable", IEN_OFS, 32'h0);
    rd("status", STS_OFS, 32'h0);
    rd("counter", CNT_OFS, 32'h0);
    rd("prescaler", PSC_OFS, 32'h0);
    rd("reload", AR_OFS, 32'h0000FFFF);
    rd("event gen", EVTGEN_OFS, 32'h0);
    axiRead(8'h20, d, r);
    chkResp("unmapped read", RESP_SLVERR, r);
    axiWrite(STS_OFS, 32'h1, r);
    chkResp("status write", RESP_SLVERR, r);
    rd("status kept", STS_OFS, 32'h0);
    $display("test reset done");
  endtask : testReset

  task automatic testModes();
    wr(IEN_OFS, 32'h00000100);
    wr(AR_OFS, 32'h5);
    wr(PSC_OFS, 32'h1);
    wr(EVTGEN_OFS, 32'h1);
    wr(CTRL_OFS, RUN);
    waitPulse();
    pulseGap("up period", 12);
    wr(PSC_OFS, 32'h3);
    waitPulse();
    pulseGap("new prescale", 24);
    wr(CTRL_OFS, RUN | DOWN);
    waitPulse();
    pulseGap("down period", 24);
    // direction bit left set: centre modes must ignore it
    for (int m = 1; m < 4; m++) begin
      wr(CTRL_OFS, RUN | DOWN | (32'(m) << CTRL_CAM_LO));
      wr(EVTGEN_OFS, 32'h1);
      waitPulse();
      pulseGap("center half", 20);
    end
    $display("test modes done");
  endtask : testModes

  task automatic testReload();
    wr(CTRL_OFS, RUN);
    wr(PSC_OFS, 32'h1);
    wr(EVTGEN_OFS, 32'h1);
    // prescale 2 leaves time for the write before the count passes 5
    waitPulse();
    wr(AR_OFS, 32'h14);
    pulseGap("direct reload", 42);
    wr(CTRL_OFS, RUN | ARPE);
    waitPulse();
    wr(AR_OFS, 32'h9);
    pulseGap("deferred reload", 42);
    pulseGap("reload applied", 20);
    rd("reload preload", AR_OFS, 32'h9);
    $display("test reload done");
  endtask : testReload

  task automatic testDisable();
    int seen;
    seen = 0;
    wr(CTRL_OFS, RUN | ARPE | UDIS);
    wr(AR_OFS, 32'h3);
    wr(PSC_OFS, 32'h2);
    wr(EVTGEN_OFS, 32'h1);
    repeat (3) @(negedge clk);
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      if (dmaReq === 1'b1) seen++;
    end
    chk("pulses while disabled", 32'h0, 32'(seen));
    wr(CTRL_OFS, RUN | ARPE);
    waitPulse();
    pulseGap("after enable", 12);
    $display("test disable done");
  endtask : testDisable

  task automatic testSoftware();
    wr(CTRL_OFS, URS);
    wr(IEN_OFS, 32'h1);
    wr(CLR_OFS, 32'h1);
    wr(CNT_OFS, 32'h7);
    repeat (20) @(posedge clk);
    rd("stopped counter", CNT_OFS, 32'h7);
    wr(EVTGEN_OFS, 32'h1);
    rd("counter cleared", CNT_OFS, 32'h0);
    rd("no flag", STS_OFS, 32'h0);
    rd("generate clears", EVTGEN_OFS, 32'h0);
    chk("irq quiet", 32'h0, 32'(irqOut));
    wr(CTRL_OFS, 32'h0);
    wr(EVTGEN_OFS, 32'h1);
    rd("flag set", STS_OFS, 32'h1);
    @(negedge clk);
    chk("irq raised", 32'h1, 32'(irqOut));
    wr(IEN_OFS, 32'h0);
    repeat (2) @(negedge clk);
    chk("irq masked", 32'h0, 32'(irqOut));
    rd("flag sticky", STS_OFS, 32'h1);
    wr(IEN_OFS, 32'h1);
    wr(CLR_OFS, 32'h1);
    rd("flag cleared", STS_OFS, 32'h0);
    repeat (2) @(negedge clk);
    chk("irq cleared", 32'h0, 32'(irqOut));
    $display("test software done");
  endtask : testSoftware

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    t0 = 0;
    n_fail = 0;
    compares = 0;
    awAddr = 8'h00;
    awValid = 1'b0;
    wData = 32'h0;
    wValid = 1'b0;
    bReady = 1'b0;
    arAddr = 8'h00;
    arValid = 1'b0;
    rReady = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testModes();
    testReload();
    testDisable();
    testSoftware();
    results();
  end
endmodule : tb
`default_nettype wire
